// *** core/rap_checker.sv ***
/*
 region register file and per-access permission and attribute check.
 assumes register writes come from the processor's private register port and that
 one access is presented per cycle; results are returned one cycle later.
*/
`timescale 1ns/1ps
module rap_checker (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              reg_wr_i,
   input  wire logic [5:0]        reg_addr_i,
   input  wire logic [3:0]        reg_be_i,
   input  wire logic [31:0]       reg_wdata_i,
   output logic [31:0]            reg_rdata_o,
   input  wire logic              acc_valid_i,
   input  wire logic [31:0]       acc_addr_i,
   input  wire logic              acc_write_i,
   input  wire logic              acc_fetch_i,
   input  wire logic              acc_priv_i,
   input  wire logic [7:0]        fault_clr_i,
   output logic                   acc_done_o,
   output logic                   acc_hit_o,
   output logic [2:0]             acc_region_o,
   output rap_pkg::rap_mem_type   mem_type_o,
   output logic                   shareable_o,
   output logic [1:0]             inner_policy_o,
   output logic [1:0]             outer_policy_o,
   output logic                   fault_o,
   output logic [7:0]             fault_status_o,
   output logic [31:0]            fault_addr_o
);
   logic [2:0]  select_reg;
   logic [31:0] base_reg [rap_pkg::NUM_REGIONS];
   logic [31:0] attr_reg [rap_pkg::NUM_REGIONS];
   logic [rap_pkg::NUM_REGIONS-1:0] hits;
   logic        wr_base;
   logic        wr_attr;
   logic [2:0]  top_idx;
   logic        any_hit;
   logic [31:0] sel_attr;
   logic [2:0]  type_extension;
   logic [2:0]  ap;
   logic        c_bit;
   logic        b_bit;
   logic        s_bit;
   logic        perm_ok;
   logic        violation;
   rap_pkg::rap_mem_type type_next;
   logic        share_next;
   logic [1:0]  inner_next;
   logic [1:0]  outer_next;

   // each register may be written alone or within a burst
   // aliases decode to the same storage
   assign wr_base = reg_wr_i && (reg_addr_i == rap_pkg::OFF_BASE || reg_addr_i == rap_pkg::OFF_BASE_A1 ||
                                 reg_addr_i == rap_pkg::OFF_BASE_A2 || reg_addr_i == rap_pkg::OFF_BASE_A3);
   assign wr_attr = reg_wr_i && (reg_addr_i == rap_pkg::OFF_ATTR || reg_addr_i == rap_pkg::OFF_ATTR_A1 ||
                                 reg_addr_i == rap_pkg::OFF_ATTR_A2 || reg_addr_i == rap_pkg::OFF_ATTR_A3);

   // region select, also moved by a base write with valid set
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         select_reg <= rap_pkg::SELECT_RESET;
      end else if (reg_wr_i && reg_addr_i == rap_pkg::OFF_SELECT && reg_be_i[0]) begin
         select_reg <= reg_wdata_i[2:0];
      end else if (wr_base && reg_wdata_i[rap_pkg::BASE_VALID_POS]) begin
         select_reg <= reg_wdata_i[2:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < rap_pkg::NUM_REGIONS; gi++) begin : g_region
         logic [2:0] tgt;
         assign tgt = (wr_base && reg_wdata_i[rap_pkg::BASE_VALID_POS]) ? reg_wdata_i[2:0] : select_reg;
         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               base_reg[gi] <= rap_pkg::BASE_RESET;
            end else if (wr_base && tgt == 3'(gi)) begin
               base_reg[gi] <= {reg_wdata_i[31:rap_pkg::BASE_ADDR_LSB], 5'h00};
            end
         end
         // byte lanes let halfword writes touch attributes or size alone
         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               attr_reg[gi] <= rap_pkg::ATTR_RESET;
            end else if (wr_attr && select_reg == 3'(gi)) begin
               for (int k = 0; k < 4; k++) begin
                  if (reg_be_i[k]) begin
                     attr_reg[gi][8*k +: 8] <= reg_wdata_i[8*k +: 8] & rap_pkg::ATTR_WMASK[8*k +: 8];
                  end
               end
            end
         end
         rap_region_match u_match (
            .base_i (base_reg[gi]),
            .attr_i (attr_reg[gi]),
            .addr_i (acc_addr_i),
            .hit_o  (hits[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_addr_i == rap_pkg::OFF_SELECT) begin
         reg_rdata_o <= {29'h0000_0000, select_reg};
      end else if (wr_base || reg_addr_i == rap_pkg::OFF_BASE || reg_addr_i == rap_pkg::OFF_BASE_A1 ||
                   reg_addr_i == rap_pkg::OFF_BASE_A2 || reg_addr_i == rap_pkg::OFF_BASE_A3) begin
         // valid reads as zero; region field shows the current select
         reg_rdata_o <= {base_reg[select_reg][31:5], 2'h0, select_reg};
      end else if (reg_addr_i == rap_pkg::OFF_ATTR || reg_addr_i == rap_pkg::OFF_ATTR_A1 ||
                   reg_addr_i == rap_pkg::OFF_ATTR_A2 || reg_addr_i == rap_pkg::OFF_ATTR_A3) begin
         reg_rdata_o <= attr_reg[select_reg];
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   always_comb begin
      top_idx = 3'h0;
      any_hit = 1'b0;
      for (int r = 0; r < rap_pkg::NUM_REGIONS; r++) begin
         if (hits[r]) begin
            top_idx = 3'(r);
            any_hit = 1'b1;
         end
      end
   end

   assign sel_attr = attr_reg[top_idx];
   assign type_extension   = sel_attr[rap_pkg::ATTR_TEX_LSB +: 3];
   assign ap    = sel_attr[rap_pkg::ATTR_AP_LSB +: 3];
   assign c_bit = sel_attr[rap_pkg::ATTR_C_POS];
   assign b_bit = sel_attr[rap_pkg::ATTR_B_POS];
   assign s_bit = sel_attr[rap_pkg::ATTR_S_POS];

   always_comb begin
      type_next  = rap_pkg::MT_NORMAL;
      share_next = s_bit;
      inner_next = rap_pkg::POL_NONCACHE;
      outer_next = rap_pkg::POL_NONCACHE;
      if (type_extension[2]) begin
         inner_next = {c_bit, b_bit};
         outer_next = type_extension[1:0];
      end else if (type_extension == 3'h0) begin
         case ({c_bit, b_bit})
            // fixed sharing for ordered and device
            2'b00: begin
               type_next  = rap_pkg::MT_STRONG;
               share_next = 1'b1;
            end
            2'b01: begin
               type_next  = rap_pkg::MT_DEVICE_SH;
               share_next = 1'b1;
            end
            2'b10: begin
               inner_next = rap_pkg::POL_WT;
               outer_next = rap_pkg::POL_WT;
            end
            default: begin
               inner_next = rap_pkg::POL_WB;
               outer_next = rap_pkg::POL_WB;
            end
         endcase
      end else if (type_extension == 3'h1) begin
         case ({c_bit, b_bit})
            2'b00: begin
               type_next = rap_pkg::MT_NORMAL;
            end
            2'b11: begin
               inner_next = rap_pkg::POL_WB_ALLOC;
               outer_next = rap_pkg::POL_WB_ALLOC;
            end
            2'b01: begin
               type_next  = rap_pkg::MT_RESERVED;
               share_next = 1'b0;
            end
            default: begin
               type_next  = rap_pkg::MT_IMPDEF;
               share_next = 1'b0;
            end
         endcase
      end else if (type_extension == 3'h2 && {c_bit, b_bit} == 2'b00) begin
         type_next  = rap_pkg::MT_DEVICE_NSH;
         share_next = 1'b0;
      end else begin
         type_next  = rap_pkg::MT_RESERVED;
         share_next = 1'b0;
      end
   end

   // permission table; 100 treated as no access
   always_comb begin
      case (ap)
         3'h1:    perm_ok = acc_priv_i;
         3'h2:    perm_ok = acc_priv_i || !acc_write_i;
         3'h3:    perm_ok = 1'b1;
         3'h5:    perm_ok = acc_priv_i && !acc_write_i;
         3'h6:    perm_ok = !acc_write_i;
         3'h7:    perm_ok = !acc_write_i;
         default: perm_ok = 1'b0;
      endcase
   end

   assign violation = !any_hit || !perm_ok || (acc_fetch_i && sel_attr[rap_pkg::ATTR_XN_POS]);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_done_o     <= 1'b0;
         acc_hit_o      <= 1'b0;
         acc_region_o   <= 3'h0;
         mem_type_o     <= rap_pkg::MT_STRONG;
         shareable_o    <= 1'b0;
         inner_policy_o <= rap_pkg::POL_NONCACHE;
         outer_policy_o <= rap_pkg::POL_NONCACHE;
         fault_o        <= 1'b0;
      end else begin
         acc_done_o     <= acc_valid_i;
         acc_hit_o      <= acc_valid_i && any_hit;
         acc_region_o   <= top_idx;
         mem_type_o     <= type_next;
         shareable_o    <= share_next;
         inner_policy_o <= inner_next;
         outer_policy_o <= outer_next;
         fault_o        <= acc_valid_i && violation;
      end
   end

   // sticky cause bits; a new fault wins over a clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_status_o <= rap_pkg::FS_RESET;
         fault_addr_o   <= 32'h0000_0000;
      end else begin
         fault_status_o <= fault_status_o & ~fault_clr_i;
         if (acc_valid_i && violation) begin
            if (acc_fetch_i) begin
               fault_status_o[rap_pkg::FS_IACC_POS] <= 1'b1;
            end else begin
               fault_status_o[rap_pkg::FS_DACC_POS]  <= 1'b1;
               fault_status_o[rap_pkg::FS_ADDRV_POS] <= 1'b1;
               fault_addr_o <= acc_addr_i;
            end
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_req_nohit;
      acc_valid_i && !any_hit;
   endsequence
   sequence s_fault_out;
      fault_o && acc_done_o && !acc_hit_o;
   endsequence

   chk_nohit_fault: assert property (s_req_nohit |=> s_fault_out)
      else $error("unmatched access did not fault");
   chk_xn_fetch: assert property (acc_valid_i && acc_fetch_i && any_hit && sel_attr[rap_pkg::ATTR_XN_POS]
                                  |=> fault_o ##1 !fault_o || acc_done_o)
      else $error("fetch from execute-never region passed");
   chk_ap_none: assert property (acc_valid_i && any_hit && ap == 3'h0 |=> fault_o)
      else $error("no-access region did not fault");
   chk_ro_write: assert property (acc_valid_i && acc_write_i && any_hit && ap[2] |=> fault_o)
      else $error("write to read-only region passed");
   chk_fault_status: assert property (fault_o |-> fault_status_o[1:0] != 2'h0)
      else $error("fault without status cause");
   chk_select_move: assert property (wr_base && reg_wdata_i[rap_pkg::BASE_VALID_POS]
                                     |=> select_reg == $past(reg_wdata_i[2:0]))
      else $error("valid base write did not move select");
   chk_strong_type: assert property (acc_valid_i && any_hit && type_extension == 3'h0 && !c_bit && !b_bit
                                     |=> mem_type_o == rap_pkg::MT_STRONG && shareable_o)
      else $error("strongly ordered decode wrong");
   chk_hit_enabled: assert property (acc_hit_o |-> attr_reg[acc_region_o][rap_pkg::ATTR_EN_POS]
                                     || $past(reg_wr_i))
      else $error("disabled region reported a hit");
   chk_full_ok: assert property (acc_valid_i && any_hit && ap == 3'h3 && !acc_fetch_i |=> !fault_o)
      else $error("full access region faulted");
endmodule : rap_checker

// *** core/rap_pkg.sv ***
/*
 constants, field layout and attribute encodings shared by the region checker.
 assumes a single processor clock; register offsets are byte offsets from the region select register.
*/
// Overview of operation
// - subregion bit clear keeps subregion active; set excludes it from match
// - region bytes are two to the power size plus one; size 4 to 31
// - region base is base bits 31 down to log2 of region size
// - ext 000 with c0 gives strongly ordered or shared device; ext 010 with c0 b0 gives unshared device
// - shareable bit ignored for strongly ordered, device, reserved and custom encodings
// - ext 000 with c1 b0 is write-through normal, no write allocate
// - ext 000 with c1 b1 is write-back normal, no write allocate
// - ext 001: 00 normal, 11 write-back allocate, 01 reserved, 10 custom
// - ext 4 to 7 is normal; two-bit codes give cache policy per level
// - permission 000 none, 001 privileged only, 010 user read, 011 full
// - permission 101 privileged read only; 110 and 111 read only; 100 reserved
// - execute-never set refuses instruction fetches from the region
// - any access not allowed by region settings raises a permission fault
// - violation signals a fault and records its cause in fault status
// - base and attribute aliases let one burst program up to four regions
// - eight regions, selected by region number 0 to 7
package rap_pkg;
   localparam int NUM_REGIONS = 8;
   localparam logic [5:0] OFF_SELECT = 6'h00;
   localparam logic [5:0] OFF_BASE   = 6'h04;
   localparam logic [5:0] OFF_ATTR   = 6'h08;
   localparam logic [5:0] OFF_BASE_A1 = 6'h0C;
   localparam logic [5:0] OFF_ATTR_A1 = 6'h10;
   localparam logic [5:0] OFF_BASE_A2 = 6'h14;
   localparam logic [5:0] OFF_ATTR_A2 = 6'h18;
   localparam logic [5:0] OFF_BASE_A3 = 6'h1C;
   localparam logic [5:0] OFF_ATTR_A3 = 6'h20;
   // attribute register fields
   localparam int ATTR_EN_POS   = 0;
   localparam int ATTR_SIZE_LSB = 1;
   localparam int ATTR_SRD_LSB  = 8;
   localparam int ATTR_B_POS    = 16;
   localparam int ATTR_C_POS    = 17;
   localparam int ATTR_S_POS    = 18;
   localparam int ATTR_TEX_LSB  = 19;
   localparam int ATTR_AP_LSB   = 24;
   localparam int ATTR_XN_POS   = 28;
   localparam logic [31:0] ATTR_WMASK = 32'h173F_FF3F;
   localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [2:0]  SELECT_RESET = 3'h0;
   // base register fields and size limits
   localparam int BASE_VALID_POS = 4;
   localparam int BASE_ADDR_LSB  = 5;
   localparam logic [4:0] SIZE_MIN = 5'h04;
   localparam logic [4:0] SIZE_SUBREG_MIN = 5'h07;
   // fault status bits
   localparam int FS_IACC_POS  = 0;
   localparam int FS_DACC_POS  = 1;
   localparam int FS_ADDRV_POS = 7;
   localparam logic [7:0] FS_RESET = 8'h00;
   // cache policy codes
   localparam logic [1:0] POL_NONCACHE = 2'h0;
   localparam logic [1:0] POL_WB_ALLOC = 2'h1;
   localparam logic [1:0] POL_WT       = 2'h2;
   localparam logic [1:0] POL_WB       = 2'h3;
   typedef enum logic [2:0] {
      MT_STRONG,
      MT_DEVICE_SH,
      MT_DEVICE_NSH,
      MT_NORMAL,
      MT_RESERVED,
      MT_IMPDEF
   } rap_mem_type;
endpackage : rap_pkg

// *** core/rap_region_match.sv ***
/*
 address match of one protection region against one access address.
 assumes base and attribute words are held by the caller.
*/
`timescale 1ns/1ps
module rap_region_match (
   input  wire logic [31:0] base_i,
   input  wire logic [31:0] attr_i,
   input  wire logic [31:0] addr_i,
   output logic             hit_o
);
   logic [4:0]  size_f;
   logic [5:0]  n_bits;
   logic [31:0] low_mask;
   logic [2:0]  sub_idx;
   logic [7:0]  subregion_disable;
   logic        in_range;
   logic        sub_off;

   assign size_f = attr_i[rap_pkg::ATTR_SIZE_LSB +: 5];
   assign subregion_disable    = attr_i[rap_pkg::ATTR_SRD_LSB +: 8];
   assign n_bits = {1'b0, size_f} + 6'h01;
   // shifting by 32 yields zero, so a 4 GB region masks every bit
   assign low_mask = ~(32'hFFFF_FFFF << n_bits);
   assign in_range = ((addr_i ^ base_i) & ~low_mask) == 32'h0000_0000;
   assign sub_idx  = 3'((addr_i & low_mask) >> (n_bits - 6'h03));
   // subregion exclusion; ignored below 256 bytes
   assign sub_off = (size_f >= rap_pkg::SIZE_SUBREG_MIN) && subregion_disable[sub_idx];
   // enabled regions only; illegal small sizes never match
   assign hit_o = attr_i[rap_pkg::ATTR_EN_POS] && (size_f >= rap_pkg::SIZE_MIN) && in_range && !sub_off;
endmodule : rap_region_match

// *** testbench/rap_core_model.sv ***
/*
 behavioural processor core: register stores, register reads and memory accesses.
 assumes its tasks are called just after a rising clock edge, one at a time.
*/
`timescale 1ns/1ps
module rap_core_model (
   input  wire logic   clk_i,
   output logic        reg_wr_o,
   output logic [5:0]  reg_addr_o,
   output logic [3:0]  reg_be_o,
   output logic [31:0] reg_wdata_o,
   output logic        acc_valid_o,
   output logic [31:0] acc_addr_o,
   output logic        acc_write_o,
   output logic        acc_fetch_o,
   output logic        acc_priv_o,
   output logic [7:0]  fault_clr_o
);
   localparam time DLY = 1;
   initial begin
      {reg_wr_o, reg_addr_o, reg_be_o, reg_wdata_o} = '0;
      {acc_valid_o, acc_addr_o, acc_write_o, acc_fetch_o, acc_priv_o, fault_clr_o} = '0;
   end
   task automatic reg_write(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk_i);
      #DLY;
      {reg_wr_o, reg_addr_o, reg_be_o, reg_wdata_o} = {1'b1, a, be, d};
      @(posedge clk_i);
      #DLY;
      reg_wr_o = 1'b0;
      // a released bus never shows the last word
      reg_wdata_o = ~d;
   endtask : reg_write
   task automatic reg_read(input logic [5:0] a);
      @(posedge clk_i);
      #DLY;
      reg_addr_o = a;
      @(posedge clk_i);
      #DLY;
   endtask : reg_read
   task automatic access(input logic [31:0] a, input logic w, input logic f, input logic p);
      @(posedge clk_i);
      #DLY;
      {acc_valid_o, acc_addr_o, acc_write_o, acc_fetch_o, acc_priv_o} = {1'b1, a, w, f, p};
      @(posedge clk_i);
      #DLY;
      {acc_valid_o, acc_addr_o, acc_write_o} = {1'b0, ~a, ~w};
   endtask : access
   task automatic clear(input logic [7:0] b);
      @(posedge clk_i);
      #DLY;
      fault_clr_o = b;
      @(posedge clk_i);
      #DLY;
      fault_clr_o = 8'h00;
   endtask : clear
endmodule : rap_core_model

// *** testbench/tb.sv ***
/*
 self-checking bench for the region checker, with a queue-free integer model of the regions.
 assumes the core model drives all inputs but clock and reset; results are checked one cycle after each request.
*/
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, acc_valid, acc_write, acc_fetch, acc_priv, acc_done, acc_hit, shareable, fault;
   logic [5:0] reg_addr;
   logic [3:0] reg_be;
   logic [31:0] reg_wdata, reg_rdata, acc_addr, fault_addr;
   logic [7:0] fault_clr, fault_status;
   logic [2:0] acc_region;
   logic [1:0] inner_pol, outer_pol;
   rap_pkg::rap_mem_type mem_type;
   int fails = 0;
   int checks_done = 0;
   int seed = 32'h3867_AFFC;
   logic [31:0] base_m [8] = '{default: 32'h0};
   logic [31:0] attr_m [8] = '{default: 32'h0};
   logic [2:0] sel_m = 3'h0;
   logic [7:0] fs_m = 8'h00;
   logic [31:0] fa_m = 32'h0;
   always #10 clk = ~clk;
   rap_checker dut (.clk_i(clk), .rstn_i(rst_n), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_be_i(reg_be),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .acc_valid_i(acc_valid), .acc_addr_i(acc_addr),
      .acc_write_i(acc_write), .acc_fetch_i(acc_fetch), .acc_priv_i(acc_priv), .fault_clr_i(fault_clr),
      .acc_done_o(acc_done), .acc_hit_o(acc_hit), .acc_region_o(acc_region), .mem_type_o(mem_type),
      .shareable_o(shareable), .inner_policy_o(inner_pol), .outer_policy_o(outer_pol), .fault_o(fault),
      .fault_status_o(fault_status), .fault_addr_o(fault_addr));
   rap_core_model core (.clk_i(clk), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_be_o(reg_be),
      .reg_wdata_o(reg_wdata), .acc_valid_o(acc_valid), .acc_addr_o(acc_addr), .acc_write_o(acc_write),
      .acc_fetch_o(acc_fetch), .acc_priv_o(acc_priv), .fault_clr_o(fault_clr));
   task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_reg
   task automatic cmp_acc(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_acc
   task automatic test_done;
      if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   function automatic int rnd(input int n);
      return int'({$random(seed)} % n);
   endfunction : rnd
   function automatic logic [31:0] rd_m(input logic [5:0] a);
      case (a)
         6'h00: return {29'h0, sel_m};
         6'h04, 6'h0C, 6'h14, 6'h1C: return {base_m[sel_m][31:5], 2'b00, sel_m};
         6'h08, 6'h10, 6'h18, 6'h20: return attr_m[sel_m];
         default: return 32'h0;
      endcase
   endfunction : rd_m
   task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rap_pkg::ATTR_WMASK;
      core.reg_write(a, be, d);
      case (a)
         6'h00: if (be[0]) sel_m = d[2:0];
         6'h04, 6'h0C, 6'h14, 6'h1C: begin
            if (d[4]) sel_m = d[2:0];
            base_m[sel_m] = d & 32'hFFFF_FFE0;
         end
         6'h08, 6'h10, 6'h18, 6'h20: attr_m[sel_m] = (attr_m[sel_m] & ~m) | (d & m);
         default: ;
      endcase
   endtask : wr
   task automatic rd(input logic [5:0] a);
      core.reg_read(a);
      cmp_reg("reg_rdata", rd_m(a), reg_rdata);
   endtask : rd
   function automatic bit m_hit(input int r, input logic [31:0] a);
      int sz;
      sz = int'(attr_m[r][5:1]);
      if (!attr_m[r][0] || sz < 4) return 0;
      if (sz < 31 && (a >> (sz + 1)) != (base_m[r] >> (sz + 1))) return 0;
      // small regions have no subregions, so their disable bits are never looked at
      if (sz >= 7 && attr_m[r][8 + ((a >> (sz - 2)) & 7)]) return 0;
      return 1;
   endfunction : m_hit
   task automatic decode(input logic [31:0] at, output rap_pkg::rap_mem_type mt, output logic sh,
                         output logic [1:0] ip, output logic [1:0] op);
      // plain bits here: an enum may not sit inside a concatenated target
      logic [2:0] t;
      {t, sh, ip, op} = {rap_pkg::MT_NORMAL, at[18], at[17:16], at[20:19]};
      if (!at[21]) case ({at[20:19], at[17:16]})
         4'h0: {t, sh} = {rap_pkg::MT_STRONG, 1'b1};
         4'h1: {t, sh} = {rap_pkg::MT_DEVICE_SH, 1'b1};
         4'h2: {ip, op} = {rap_pkg::POL_WT, rap_pkg::POL_WT};
         4'h3: {ip, op} = {rap_pkg::POL_WB, rap_pkg::POL_WB};
         4'h4: {ip, op} = {rap_pkg::POL_NONCACHE, rap_pkg::POL_NONCACHE};
         4'h6: {t, sh} = {rap_pkg::MT_IMPDEF, 1'b0};
         4'h7: {ip, op} = {rap_pkg::POL_WB_ALLOC, rap_pkg::POL_WB_ALLOC};
         4'h8: {t, sh} = {rap_pkg::MT_DEVICE_NSH, 1'b0};
         default: {t, sh} = {rap_pkg::MT_RESERVED, 1'b0};
      endcase
      mt = rap_pkg::rap_mem_type'(t);
   endtask : decode
   task automatic acc(input logic [31:0] a, input logic w, input logic f, input logic p);
      int win;
      logic hit, ok, flt, sh;
      logic [1:0] ip, op;
      rap_pkg::rap_mem_type mt;
      hit = 1'b0;
      win = 0;
      for (int r = 0; r < 8; r++) if (m_hit(r, a)) {hit, win} = {1'b1, r};
      case (attr_m[win][26:24])
         3'h1: ok = p;
         3'h2: ok = p || !w;
         3'h3: ok = 1'b1;
         3'h5: ok = p && !w;
         3'h6, 3'h7: ok = !w;
         default: ok = 1'b0;
      endcase
      flt = !hit || !ok || (f && attr_m[win][28]);
      decode(attr_m[win], mt, sh, ip, op);
      core.access(a, w, f, p);
      if (flt && f) fs_m[0] = 1'b1;
      if (flt && !f) {fs_m[7], fs_m[1], fa_m} = {2'b11, a};
      cmp_acc("acc_done", 32'h1, acc_done);
      cmp_acc("acc_hit", hit, acc_hit);
      cmp_acc("fault", flt, fault);
      cmp_acc("fault_status", fs_m, fault_status);
      cmp_acc("fault_addr", fa_m, fault_addr);
      if (hit) begin
         cmp_acc("acc_region", win, acc_region);
         cmp_acc("mem_type", mt, mem_type);
         cmp_acc("shareable", sh, shareable);
         if (mt == rap_pkg::MT_NORMAL) cmp_acc("policy", {ip, op}, {inner_pol, outer_pol});
      end
   endtask : acc
   task automatic cfg_region(input int r);
      int sz;
      logic [31:0] at, bs;
      sz = rnd(8) == 0 ? 31 : 4 + rnd(14);
      bs = (32'h2000_0000 | (32'($random(seed)) & 32'h0003_FFFF)) & (32'hFFFF_FFFF << (sz + 1));
      at = 32'($random(seed)) & rap_pkg::ATTR_WMASK;
      at[0] = rnd(5) != 0;
      at[5:1] = sz[4:0];
      // small regions get an all-zero disable field
      if (sz < 7) at[15:8] = 8'h00;
      wr(6'h00, 4'h1, 32'(r));
      wr(6'h04, 4'hF, bs);
      wr(6'h08, 4'hF, at);
   endtask : cfg_region
   initial begin
      #1_000_000;
      fails++;
      test_done();
   end
   initial begin
      logic [7:0] b;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      cmp_acc("fault_status", 32'h0, fault_status);
      for (int k = 0; k < 3; k++) rd(6'(4 * k));
      // aliases program four regions in one burst
      for (int k = 0; k < 4; k++) begin
         wr(6'(4 + 8 * k), 4'hF, 32'h1000_0000 | 32'(k << 12) | 32'h10 | 32'(4 + k));
         wr(6'(8 + 8 * k), 4'hF, 32'h030B_0017 + 32'(k << 24));
      end
      for (int k = 0; k < 4; k++) rd(6'(4 + 8 * k));
      for (int k = 0; k < 12; k++) acc(32'h1000_0000 | 32'(k << 10), k[0], k[1], k[2]);
      wr(6'h08, 4'hF, 32'hFFFF_FFFF);
      rd(6'h08);
      wr(6'h08, 4'h3, 32'h0);
      rd(6'h08);
      wr(6'h00, 4'hE, 32'h1);
      wr(6'h24, 4'hF, 32'hFFFF_FFFF);
      rd(6'h00);
      rd(6'h24);
      repeat (25) begin
         repeat (3) cfg_region(rnd(8));
         repeat (40) acc(rnd(4) == 0 ? 32'($random(seed)) : 32'h2000_0000 | (32'($random(seed)) & 32'h7FFFF),
                         1'(rnd(2)), 1'(rnd(3) == 0), 1'(rnd(2)));
         rd(6'(4 * rnd(10)));
         b = 8'(rnd(256));
         core.clear(b);
         fs_m = fs_m & ~b;
         cmp_acc("fault_status", fs_m, fault_status);
      end
      test_done();
   end
endmodule : tb
